// file: include/bppl_pkg.sv
// Shared constants and types for the bidirectional port pin logic
package bppl_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [5:0] OFS_PC_PIN = 6'h00;
  localparam logic [5:0] OFS_PC_LAT = 6'h04;
  localparam logic [5:0] OFS_PC_DIR = 6'h08;
  localparam logic [5:0] OFS_ODSEL  = 6'h0c;
  localparam logic [5:0] OFS_PD_PIN = 6'h10;
  localparam logic [5:0] OFS_PD_LAT = 6'h14;
  localparam logic [5:0] OFS_PD_DIR = 6'h18;
  localparam logic [5:0] OFS_PADCFG = 6'h1c;
  localparam logic [5:0] OFS_PSPCTL = 6'h20;

  // Reset values
  localparam logic [7:0] RST_LAT    = 8'h00;
  localparam logic [7:0] RST_DIR    = 8'hff;
  localparam logic [7:0] RST_ODSEL  = 8'h00;
  localparam logic [7:0] RST_PADCFG = 8'h80;
  localparam logic [7:0] RST_PSPCTL = 8'h00;

  // Field positions
  localparam int unsigned PADCFG_PU_DIS = 7;
  localparam int unsigned PSPCTL_EN     = 4;
  localparam int unsigned OD_UART1      = 0;
  localparam int unsigned OD_CAPTURE_COMPARE_4       = 5;
  localparam int unsigned TOP_PIN       = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    REG_PC_PIN = 4'h0,
    REG_PC_LAT = 4'h1,
    REG_PC_DIR = 4'h2,
    REG_ODSEL  = 4'h3,
    REG_PD_PIN = 4'h4,
    REG_PD_LAT = 4'h5,
    REG_PD_DIR = 4'h6,
    REG_PADCFG = 4'h7,
    REG_PSPCTL = 4'h8,
    REG_NONE   = 4'hf
  } bppl_reg_e;

  // Registered drive of one eight-pin port
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } bppl_pad_s;

endpackage : bppl_pkg

// file: rtl/bppl_top.sv
// Port C top pin and port D pin logic with an AXI4-Lite register slave
// What this block does
// - Port D has eight pins, one bit each in pin, latch, direction.
// - Direction bit clear drives latch onto pin; set makes pin input.
// - Each port D pin chooses direction independently via own bit.
// - Any reset makes all port D pins inputs, direction bits set.
// - Pad config bit 7 disables all eight port D pull-ups together.
// - A pin's pull-up is forced off while it is an output.
// - Reset leaves port D pull-ups disabled.
// - Parallel slave control bit 4 makes port D a parallel data port.
// - In parallel slave mode direction bits do not decide drive.
// - Capture/compare 4 output replaces latch on port C top pin.
// - UART1 sync data overrides latch and direction; pin drives even with direction set.
// - Top pin as input feeds UART1 receive and capture 4 input.
// - CAN receive taken from top pin only when remap bit set.
// - Port D low pins as inputs connect to comparator inputs outside parallel mode.
// - Port D pin 3 always carries charge unit current to comparator 2.
// - Port C has pin, latch, direction and open-drain select registers.
// - Port D can be left out by a build parameter.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module bppl_top #(
  parameter bit PORT_D_EN = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // AXI4-Lite write
  input  wire logic [5:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  // AXI4-Lite read
  input  wire logic [5:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // Port C pads
  input  wire logic [7:0]  pc_pin_i,
  output logic [7:0]       pc_out_o,
  output logic [7:0]       pc_oe_o,
  // Port D pads
  input  wire logic [7:0]  pd_pin_i,
  output logic [7:0]       pd_out_o,
  output logic [7:0]       pd_oe_o,
  output logic [7:0]       pd_pullup_o,
  // Peripheral overrides on the port C top pin
  input  wire logic        capture_compare_4_out_en_i,
  input  wire logic        capture_compare_4_out_i,
  input  wire logic        uart1_sync_tx_i,
  input  wire logic        uart1_sync_data_i,
  input  wire logic        can_pin_remap_i,
  output logic             uart1_async_receive_o,
  output logic             uart1_sync_data_o,
  output logic             capture_compare_4_capture_o,
  output logic             can_receive_input_o,
  output logic [7:0]       open_drain_select_o,
  // Parallel slave port data path
  input  wire logic        psp_drive_i,
  input  wire logic [7:0]  psp_data_i,
  output logic             parallel_slave_enable_o,
  output logic [7:0]       psp_data_o,
  // Analog connections
  output logic [3:0]       cmp_connect_o,
  output logic             charge_unit_connect_o
);

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // Pins arrive from outside; two stages before any use
  logic [7:0] pc_meta_q, pc_sync_q, pd_meta_q, pd_sync_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_meta_q <= 8'h00;
      pc_sync_q <= 8'h00;
      pd_meta_q <= 8'h00;
      pd_sync_q <= 8'h00;
    end else begin
      pc_meta_q <= pc_pin_i;
      pc_sync_q <= pc_meta_q;
      pd_meta_q <= pd_pin_i;
      pd_sync_q <= pd_meta_q;
    end
  end

  function automatic bppl_pkg::bppl_reg_e reg_sel(input logic [5:0] a);
    case (a)
      bppl_pkg::OFS_PC_PIN: reg_sel = bppl_pkg::REG_PC_PIN;
      bppl_pkg::OFS_PC_LAT: reg_sel = bppl_pkg::REG_PC_LAT;
      bppl_pkg::OFS_PC_DIR: reg_sel = bppl_pkg::REG_PC_DIR;
      bppl_pkg::OFS_ODSEL:  reg_sel = bppl_pkg::REG_ODSEL;
      bppl_pkg::OFS_PD_PIN: reg_sel = bppl_pkg::REG_PD_PIN;
      bppl_pkg::OFS_PD_LAT: reg_sel = bppl_pkg::REG_PD_LAT;
      bppl_pkg::OFS_PD_DIR: reg_sel = bppl_pkg::REG_PD_DIR;
      bppl_pkg::OFS_PADCFG: reg_sel = bppl_pkg::REG_PADCFG;
      bppl_pkg::OFS_PSPCTL: reg_sel = bppl_pkg::REG_PSPCTL;
      default:              reg_sel = bppl_pkg::REG_NONE;
    endcase
  endfunction : reg_sel

  // Write channel: address and data held until both have arrived
  logic       aw_full_q, w_full_q, bvalid_q, wr_en;
  logic [5:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic       w_lane0_q;
  logic [1:0] bresp_q;
  bppl_pkg::bppl_reg_e wsel;

  assign s_awready_o = !aw_full_q;
  assign s_wready_o  = !w_full_q;
  assign wr_en       = aw_full_q && w_full_q && !bvalid_q;
  assign wsel        = reg_sel(aw_addr_q);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_full_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= bppl_pkg::RESP_OKAY;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_full_q  <= 1'b1;
        w_data_q  <= s_wdata_i[7:0];
        w_lane0_q <= s_wstrb_i[0];
      end
      if (wr_en) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wsel == bppl_pkg::REG_NONE) ? bppl_pkg::RESP_SLVERR
                                                  : bppl_pkg::RESP_OKAY;
      end else if (bvalid_q && s_bready_i) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o  = bresp_q;

  // Register file
  logic [7:0] port_c_output_latch_q, port_c_direction_q, odsel_q, port_d_output_latch_q, port_d_direction_q, padcfg_q, pspctl_q;
  logic       reg_we;
  assign reg_we = wr_en && w_lane0_q;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_c_output_latch_q  <= bppl_pkg::RST_LAT;
      port_c_direction_q <= bppl_pkg::RST_DIR;
      odsel_q <= bppl_pkg::RST_ODSEL;
    end else if (reg_we) begin
      case (wsel)
        bppl_pkg::REG_PC_PIN: port_c_output_latch_q  <= w_data_q;
        bppl_pkg::REG_PC_LAT: port_c_output_latch_q  <= w_data_q;
        bppl_pkg::REG_PC_DIR: port_c_direction_q <= w_data_q;
        bppl_pkg::REG_ODSEL:  odsel_q <= w_data_q;
        default: ;
      endcase
    end
  end

  // Port D state always resets to inputs with pull-ups off
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      port_d_output_latch_q   <= bppl_pkg::RST_LAT;
      port_d_direction_q  <= bppl_pkg::RST_DIR;
      padcfg_q <= bppl_pkg::RST_PADCFG;
      pspctl_q <= bppl_pkg::RST_PSPCTL;
    end else if (reg_we && PORT_D_EN) begin
      case (wsel)
        bppl_pkg::REG_PD_PIN: port_d_output_latch_q   <= w_data_q;
        bppl_pkg::REG_PD_LAT: port_d_output_latch_q   <= w_data_q;
        bppl_pkg::REG_PD_DIR: port_d_direction_q  <= w_data_q;
        bppl_pkg::REG_PADCFG: padcfg_q <= w_data_q;
        bppl_pkg::REG_PSPCTL: pspctl_q <= w_data_q;
        default: ;
      endcase
    end
  end

  // Read channel: one cycle from address to data
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  bppl_pkg::bppl_reg_e rsel;

  assign s_arready_o = !rvalid_q;
  assign rsel        = reg_sel(s_araddr_i);

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    case (rsel)
      bppl_pkg::REG_PC_PIN: rd_byte = pc_sync_q;
      bppl_pkg::REG_PC_LAT: rd_byte = port_c_output_latch_q;
      bppl_pkg::REG_PC_DIR: rd_byte = port_c_direction_q;
      bppl_pkg::REG_ODSEL:  rd_byte = odsel_q;
      bppl_pkg::REG_PD_PIN: rd_byte = pd_sync_q;
      bppl_pkg::REG_PD_LAT: rd_byte = port_d_output_latch_q;
      bppl_pkg::REG_PD_DIR: rd_byte = port_d_direction_q;
      bppl_pkg::REG_PADCFG: rd_byte = padcfg_q;
      bppl_pkg::REG_PSPCTL: rd_byte = pspctl_q;
      default:              rd_hit  = 1'b0;
    endcase
    if (!PORT_D_EN && rsel >= bppl_pkg::REG_PD_PIN) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= bppl_pkg::RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= rd_hit ? bppl_pkg::RESP_OKAY : bppl_pkg::RESP_SLVERR;
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o  = rdata_q;
  assign s_rresp_o  = rresp_q;

  // Port C drive; only the top pin has overrides here
  localparam int unsigned T = bppl_pkg::TOP_PIN;
  bppl_pkg::bppl_pad_s pc_d, pc_q, pd_d, pd_q;
  logic [7:0] pu_d, pu_q;
  logic       top_dat, top_oe;
  logic       psp_en, pu_dis;

  always_comb begin
    top_dat = port_c_output_latch_q[T];
    top_oe  = !port_c_direction_q[T];
    if (uart1_sync_tx_i) begin
      // Open drain only pulls low, the line idles on its own pull-up
      top_dat = uart1_sync_data_i;
      top_oe  = odsel_q[bppl_pkg::OD_UART1] ? !uart1_sync_data_i : 1'b1;
    end else if (capture_compare_4_out_en_i && !port_c_direction_q[T]) begin
      top_dat = capture_compare_4_out_i;
      top_oe  = odsel_q[bppl_pkg::OD_CAPTURE_COMPARE_4] ? !capture_compare_4_out_i : 1'b1;
    end
    pc_d.dout = {top_dat, port_c_output_latch_q[T-1:0]};
    pc_d.oe   = {top_oe, ~port_c_direction_q[T-1:0]};
  end

  assign psp_en = pspctl_q[bppl_pkg::PSPCTL_EN] && PORT_D_EN;
  assign pu_dis = padcfg_q[bppl_pkg::PADCFG_PU_DIS];

  always_comb begin
    if (psp_en) begin
      pd_d.dout = psp_data_i;
      pd_d.oe   = {8{psp_drive_i}};
    end else begin
      pd_d.dout = port_d_output_latch_q;
      pd_d.oe   = ~port_d_direction_q;
    end
    pu_d = {8{!pu_dis}} & ~pd_d.oe;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc_q <= '0;
      pd_q <= '0;
      pu_q <= 8'h00;
    end else begin
      pc_q <= pc_d;
      pd_q <= pd_d;
      pu_q <= pu_d;
    end
  end

  assign pc_out_o            = pc_q.dout;
  assign pc_oe_o             = pc_q.oe;
  assign open_drain_select_o = odsel_q;

  // Peripheral inputs from the top pin; idle levels when not an input
  assign uart1_async_receive_o = port_c_direction_q[T] ? pc_sync_q[T] : 1'b1;
  assign uart1_sync_data_o     = port_c_direction_q[T] ? pc_sync_q[T] : 1'b1;
  assign capture_compare_4_capture_o        = port_c_direction_q[T] && pc_sync_q[T];
  assign can_receive_input_o   = (can_pin_remap_i && port_c_direction_q[T]) ? pc_sync_q[T] : 1'b1;

  generate
    if (PORT_D_EN) begin : g_port_d
      assign pd_out_o                = pd_q.dout;
      assign pd_oe_o                 = pd_q.oe;
      assign pd_pullup_o             = pu_q;
      assign parallel_slave_enable_o = psp_en;
      assign psp_data_o              = pd_sync_q;
      // Comparator switches close only for inputs outside parallel mode; the charge unit switch is always closed
      assign cmp_connect_o = ~port_d_direction_q[3:0] == 4'h0 ? {4{!psp_en}} : port_d_direction_q[3:0] & {4{!psp_en}};
      assign charge_unit_connect_o = 1'b1;
    end else begin : g_no_port_d
      assign pd_out_o                = 8'h00;
      assign pd_oe_o                 = 8'h00;
      assign pd_pullup_o             = 8'h00;
      assign parallel_slave_enable_o = 1'b0;
      assign psp_data_o              = 8'h00;
      assign cmp_connect_o           = 4'h0;
      assign charge_unit_connect_o   = 1'b0;
    end
  endgenerate

  a_pd_dir_drive: assert property (!psp_en |=> pd_oe_o == ~$past(port_d_direction_q) || !PORT_D_EN)
    else $error("port D drive does not follow direction");
  a_pd_latch_out: assert property (!psp_en |=> pd_out_o == $past(port_d_output_latch_q) || !PORT_D_EN)
    else $error("port D output does not follow latch");
  a_pullup_out_off: assert property ((pd_pullup_o & pd_oe_o) == 8'h00)
    else $error("pull-up on while pin drives");
  a_pullup_kill: assert property (pu_dis |=> pd_pullup_o == 8'h00)
    else $error("pull-ups not disabled");
  a_psp_drive: assert property (psp_en && psp_drive_i |=> pd_oe_o == 8'hff)
    else $error("parallel mode not driving port D");
  a_capture_compare_4_over: assert property (capture_compare_4_out_en_i && !port_c_direction_q[T] && !uart1_sync_tx_i
                                |=> pc_out_o[T] == $past(capture_compare_4_out_i))
    else $error("compare output not on top pin");
  a_uart_over: assert property (uart1_sync_tx_i |=> pc_out_o[T] == $past(uart1_sync_data_i))
    else $error("sync data not on top pin");
  // Traced back to the pad, so a broken synchroniser stage shows up here
  a_rx_route: assert property (port_c_direction_q[T] && $past(rst_n, 2)
                               |-> uart1_async_receive_o == $past(pc_pin_i[T], 2))
    else $error("receive input not fed from top pin");
  a_can_gate: assert property (!can_pin_remap_i |-> can_receive_input_o)
    else $error("CAN receive taken without remap");
  a_pin_wr_latch: assert property (reg_we && wsel == bppl_pkg::REG_PC_PIN
                                   |=> port_c_output_latch_q == $past(w_data_q))
    else $error("pin write did not update latch");
  a_reset_inputs: assert property ($rose(rst_n) |-> port_d_direction_q == bppl_pkg::RST_DIR)
    else $error("port D not inputs after reset");
  a_psp_data_out: assert property (psp_en |=> pd_out_o == $past(psp_data_i))
    else $error("parallel data not on port D");
  a_capture_compare_4_drain: assert property (capture_compare_4_out_en_i && !port_c_direction_q[T] && !uart1_sync_tx_i
                                 && odsel_q[bppl_pkg::OD_CAPTURE_COMPARE_4] |=> pc_oe_o[T] == !$past(capture_compare_4_out_i))
    else $error("open-drain compare output drives high");
  a_cmp_on_input: assert property ((cmp_connect_o & ~port_d_direction_q[3:0]) == 4'h0)
    else $error("comparator switch closed on an output pin");
  a_capture_idle: assert property (!port_c_direction_q[T] |-> !capture_compare_4_capture_o)
    else $error("capture input fed while top pin drives");
  a_pullup_dir: assert property (!psp_en |=> (pd_pullup_o & ~$past(port_d_direction_q)) == 8'h00)
    else $error("pull-up on for an output pin");

endmodule : bppl_top
`default_nettype wire

// file: dv/bppl_pad_model.sv
// Pad ring model for one eight-pin port: device drive, external drive, pull-up
`timescale 1ns/1ns
`default_nettype none
module bppl_pad_model (
  // Clock
  input  wire logic       clk_i,
  // Device side
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  // Board side
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output var  logic [7:0] pin_o
);
  logic float_q;

  // A pad nobody drives toggles, so a stale level can never pass for a real one
  always_ff @(posedge clk_i) begin
    float_q <= (float_q === 1'b1) ? 1'b0 : 1'b1;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) begin
        pin_o[i] = out_i[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_val_i[i];
      end else if (pullup_i[i]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = float_q;
      end
    end
  end
endmodule : bppl_pad_model
`default_nettype wire

// file: dv/bppl_top_tb_top.sv
// Self-checking bench for the port pin logic over its AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module bppl_top_tb_top;
  logic        clk_i, resetn_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic [5:0]  s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o;
  logic [3:0]  s_wstrb_i, cmp_connect_o;
  logic        s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0]  s_bresp_o, s_rresp_o;
  logic [7:0]  pc_pin_i, pc_out_o, pc_oe_o, pd_pin_i, pd_out_o, pd_oe_o, pd_pullup_o, open_drain_select_o;
  logic        capture_compare_4_out_en_i, capture_compare_4_out_i, uart1_sync_tx_i, uart1_sync_data_i, can_pin_remap_i;
  logic        uart1_async_receive_o, uart1_sync_data_o, capture_compare_4_capture_o, can_receive_input_o;
  logic        psp_drive_i, parallel_slave_enable_o, charge_unit_connect_o;
  logic [7:0]  psp_data_i, psp_data_o, pc_ext_en, pc_ext_val, pd_ext_en, pd_ext_val;
  int          fails, samples_checked;

  bppl_top dut (.clk_i, .resetn_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i,
    .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .pc_pin_i, .pc_out_o, .pc_oe_o,
    .pd_pin_i, .pd_out_o, .pd_oe_o, .pd_pullup_o, .capture_compare_4_out_en_i, .capture_compare_4_out_i, .uart1_sync_tx_i,
    .uart1_sync_data_i, .can_pin_remap_i, .uart1_async_receive_o, .uart1_sync_data_o, .capture_compare_4_capture_o,
    .can_receive_input_o, .open_drain_select_o, .psp_drive_i, .psp_data_i, .parallel_slave_enable_o,
    .psp_data_o, .cmp_connect_o, .charge_unit_connect_o);

  // Port C has no pull-ups, so an undriven pad there floats
  bppl_pad_model pc_pads (.clk_i, .out_i(pc_out_o), .oe_i(pc_oe_o), .pullup_i(8'h00),
    .ext_en_i(pc_ext_en), .ext_val_i(pc_ext_val), .pin_o(pc_pin_i));
  bppl_pad_model pd_pads (.clk_i, .out_i(pd_out_o), .oe_i(pd_oe_o), .pullup_i(pd_pullup_o),
    .ext_en_i(pd_ext_en), .ext_val_i(pd_ext_val), .pin_o(pd_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t response %h expected %h", $time, got, exp);
    end
  endtask : chk_rsp

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    bit aw_done, w_done, b_done;
    aw_done = 0;
    w_done = 0;
    b_done = 0;
    @(posedge clk_i);
    s_awaddr_i <= a;
    s_awvalid_i <= 1'b1;
    s_wdata_i <= {24'h000000, d};
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    while (!b_done) begin
      @(posedge clk_i);
      if (!aw_done && s_awready_o) begin
        aw_done = 1;
        s_awvalid_i <= 1'b0;
      end
      if (!w_done && s_wready_o) begin
        w_done = 1;
        s_wvalid_i <= 1'b0;
      end
      if (s_bvalid_o) begin
        b_done = 1;
        s_bready_i <= 1'b0;
        chk_rsp(s_bresp_o, er);
      end
    end
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] ed, input logic [1:0] er);
    bit ar_done, r_done;
    ar_done = 0;
    r_done = 0;
    @(posedge clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    while (!r_done) begin
      @(posedge clk_i);
      if (!ar_done && s_arready_o) begin
        ar_done = 1;
        s_arvalid_i <= 1'b0;
      end
      if (s_rvalid_o) begin
        r_done = 1;
        s_rready_i <= 1'b0;
        chk_val(s_rdata_o, {24'h000000, ed});
        chk_rsp(s_rresp_o, er);
      end
    end
  endtask : rd

  // Covers the registered pad path plus the two-flop pin synchroniser
  task automatic settle;
    repeat (4) @(posedge clk_i);
  endtask : settle

  initial begin
    {resetn_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
    {s_awaddr_i, s_araddr_i, s_wdata_i, psp_data_i, pc_ext_en, pc_ext_val, pd_ext_en, pd_ext_val} = '0;
    s_wstrb_i = 4'hf;
    {capture_compare_4_out_en_i, capture_compare_4_out_i, uart1_sync_tx_i, uart1_sync_data_i, can_pin_remap_i, psp_drive_i} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
    chk_val(pd_oe_o, 8'h00);
    chk_val(pd_pullup_o, 8'h00);
    rd(bppl_pkg::OFS_PD_DIR, 8'hff, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_PADCFG, 8'h80, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_PC_DIR, 8'hff, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_ODSEL, 8'h00, bppl_pkg::RESP_OKAY);
    // Mixed directions with pull-ups enabled on the remaining inputs
    wr(bppl_pkg::OFS_PD_PIN, 8'ha5, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_PD_LAT, 8'ha5, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PD_DIR, 8'hca, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PADCFG, 8'h00, bppl_pkg::RESP_OKAY);
    settle();
    chk_val(pd_oe_o, 8'h35);
    chk_val(pd_out_o & pd_oe_o, 8'h25);
    chk_val(pd_pullup_o, 8'hca);
    chk_val(cmp_connect_o, 4'ha);
    chk_val(charge_unit_connect_o, 1'b1);
    rd(bppl_pkg::OFS_PD_PIN, 8'hef, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PADCFG, 8'h80, bppl_pkg::RESP_OKAY);
    settle();
    chk_val(pd_pullup_o, 8'h00);
    // Parallel mode takes drive away from the direction bits
    wr(bppl_pkg::OFS_PSPCTL, 8'h10, bppl_pkg::RESP_OKAY);
    psp_drive_i <= 1'b1;
    psp_data_i <= 8'h3c;
    settle();
    chk_val(parallel_slave_enable_o, 1'b1);
    chk_val({pd_oe_o, pd_out_o}, 16'hff3c);
    chk_val(psp_data_o, 8'h3c);
    chk_val(cmp_connect_o, 4'h0);
    psp_drive_i <= 1'b0;
    settle();
    chk_val(pd_oe_o, 8'h00);
    wr(bppl_pkg::OFS_PSPCTL, 8'h00, bppl_pkg::RESP_OKAY);
    // Port C top pin as output with peripheral overrides
    wr(bppl_pkg::OFS_ODSEL, 8'h00, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PC_LAT, 8'h80, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PC_PIN, 8'h81, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_PC_LAT, 8'h81, bppl_pkg::RESP_OKAY);
    wr(bppl_pkg::OFS_PC_DIR, 8'h7f, bppl_pkg::RESP_OKAY);
    settle();
    chk_val({pc_oe_o[7], pc_out_o[7]}, 2'b11);
    capture_compare_4_out_en_i <= 1'b1;
    settle();
    chk_val({pc_oe_o[7], pc_out_o[7]}, 2'b10);
    // Open-drain compare output releases the pin for a high level
    wr(bppl_pkg::OFS_ODSEL, 8'h20, bppl_pkg::RESP_OKAY);
    capture_compare_4_out_i <= 1'b1;
    settle();
    chk_val(open_drain_select_o, 8'h20);
    chk_val(pc_oe_o[7], 1'b0);
    uart1_sync_tx_i <= 1'b1;
    uart1_sync_data_i <= 1'b1;
    wr(bppl_pkg::OFS_PC_DIR, 8'hff, bppl_pkg::RESP_OKAY);
    settle();
    chk_val({pc_oe_o[7], pc_out_o[7]}, 2'b11);
    // Top pin as input feeding the receivers
    {uart1_sync_tx_i, capture_compare_4_out_en_i} <= 2'b00;
    pc_ext_en <= 8'hff;
    pc_ext_val <= 8'h80;
    settle();
    rd(bppl_pkg::OFS_PC_PIN, 8'h80, bppl_pkg::RESP_OKAY);
    chk_val({uart1_async_receive_o, capture_compare_4_capture_o, uart1_sync_data_o}, 3'b111);
    pc_ext_val <= 8'h00;
    settle();
    chk_val({uart1_async_receive_o, capture_compare_4_capture_o, uart1_sync_data_o}, 3'b000);
    chk_val(can_receive_input_o, 1'b1);
    can_pin_remap_i <= 1'b1;
    settle();
    chk_val(can_receive_input_o, 1'b0);
    // Low strobe off and unmapped word: no side effect
    s_wstrb_i <= 4'he;
    wr(bppl_pkg::OFS_PD_LAT, 8'h00, bppl_pkg::RESP_OKAY);
    s_wstrb_i <= 4'hf;
    wr(6'h3c, 8'h55, bppl_pkg::RESP_SLVERR);
    rd(6'h3c, 8'h00, bppl_pkg::RESP_SLVERR);
    rd(bppl_pkg::OFS_PD_LAT, 8'ha5, bppl_pkg::RESP_OKAY);
    // Reset in mid-run puts port D back to inputs with pull-ups off
    wr(bppl_pkg::OFS_PADCFG, 8'h00, bppl_pkg::RESP_OKAY);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    settle();
    chk_val(pd_oe_o, 8'h00);
    chk_val(pd_pullup_o, 8'h00);
    rd(bppl_pkg::OFS_PADCFG, 8'h80, bppl_pkg::RESP_OKAY);
    rd(bppl_pkg::OFS_PD_DIR, 8'hff, bppl_pkg::RESP_OKAY);
    close_out();
  end

  // The sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule : bppl_top_tb_top
`default_nettype wire
